// *** tb_virtual_spi_table_valid_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_virtual_spi_table_valid_ctrl;
    import vst_pkg::*;
    logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, mem_addr, mem_wdata, mem_rdata;
    logic [1:0] htrans = 0, delay = 0;
    logic [2:0] hsize = VST_HSIZE_WORD;
    logic mem_req, mem_we, mem_ack, tacc_req = 0, tacc_done, tacc_err;
    logic ev_valid = 0, ev_ready, ev_out_valid, ev_out_ready = 0;
    logic cand_active = 0, cand_ack = 0, cand_withdraw, wd_seen = 0;
    logic [15:0] tacc_id = 0, ev_id = 0, ev_out_id;
    logic [31:0] tacc_data, rd, cnt = 0;
    int errors = 0, comparisons = 0;
    vst_ctrl uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .tacc_req(tacc_req), .tacc_id(tacc_id), .tacc_done(tacc_done),
        .tacc_err(tacc_err), .tacc_data(tacc_data), .ev_valid(ev_valid),
        .ev_id(ev_id), .ev_ready(ev_ready), .ev_out_valid(ev_out_valid),
        .ev_out_id(ev_out_id), .ev_out_ready(ev_out_ready),
        .cand_active(cand_active), .cand_ack(cand_ack),
        .cand_withdraw(cand_withdraw));
    vst_mem_model mem (.clk_sys(clk_sys), .rst(rst), .delay(delay),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    always #20 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    // Memory cycles and withdraw pulses, so silence can be proven
    always @(posedge clk_sys) begin
        if (mem_req === 1'b1) cnt <= cnt + 32'h1;
        if (cand_withdraw === 1'b1) wd_seen <= 1'b1;
    end
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0; hsel <= 0; hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Software waits for idle before the next map write, bounded
    task automatic wait_idle;
        for (int i = 0; i < 40; i++) begin
            ahb(0, VST_OFF_STATUS, 0);
            if (rd[VST_ST_IDLE] === 1'b1) break;
        end
    endtask : wait_idle
    task automatic tacc(input logic [15:0] id);
        tacc_req <= 1; tacc_id <= id;
        for (int i = 0; i < 40 && tacc_done !== 1'b1; i++) @(posedge clk_sys);
        tacc_req <= 0;
        @(posedge clk_sys);
    endtask : tacc
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        errors++;
        report_and_stop();
    end
    initial begin
        // Entry with flag 0, width 4, two-level
        mem.mem[64] = 32'h0000_1048;
        mem.mem[3] = 32'h0000_ABCD;
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        ahb(0, VST_OFF_STATUS, 0);
        `CHK(rd[VST_ST_IDLE], VST_RST_IDLE)
        ahb(0, VST_OFF_IDR2, 0);
        `CHK(rd[4:0], VST_MAX_MAX_IDENTIFIER_WIDTH_FIELD)
        ahb(1, VST_OFF_ENTRY, 32'h100);
        ahb(1, VST_OFF_CTRL, 1);
        wait_idle();
        ahb(0, VST_OFF_STATUS, 0);
        `CHK(rd[VST_ST_TVALID], 1'b0)
        rd = cnt;
        tacc(3);
        `CHK(tacc_err, 1'b1)
        `CHK(cnt, rd)
        delay <= 2'h2;
        ahb(1, VST_OFF_MAP, 1);
        wait_idle();
        `CHK(mem.mem[64], 32'h0000_1049)
        ahb(0, VST_OFF_STATUS, 0);
        `CHK(rd[VST_ST_TVALID], 1'b1)
        tacc(3);
        `CHK({tacc_err, tacc_data}, {1'b0, 32'h0000_ABCD})
        rd = cnt;
        tacc(16);
        `CHK({tacc_err, cnt}, {1'b1, rd})
        // Sub-table 2 of a two-level table, type shared
        ahb(1, VST_OFF_L2MAP, 32'h0002_0001);
        wait_idle();
        `CHK(rd[VST_ST_IDLE], 1'b1)
        `CHK(mem.mem[2], 32'h0000_0001)
        ev_valid <= 1;
        ev_id <= 16'h5;
        cand_active <= 1;
        @(posedge clk_sys);
        ev_valid <= 0;
        @(posedge clk_sys);
        `CHK(ev_out_valid, 1'b1)
        ahb(1, VST_OFF_MAP, 0);
        wait_idle();
        `CHK(mem.mem[64], 32'h0000_1048)
        `CHK(ev_out_valid, 1'b0)
        ahb(0, VST_OFF_STATUS, 0);
        `CHK(rd[2:1], 2'h1)
        `CHK(wd_seen, 1'b1)
        report_and_stop();
    end
endmodule : tb_virtual_spi_table_valid_ctrl
`default_nettype wire

// *** vst_ahb_slv.sv ***
`timescale 1ns/1ps
`default_nettype none
module vst_ahb_slv (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] rd_data,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr
);
    import vst_pkg::*;

    logic take;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;

    // Only whole-word transfers are honoured; others complete with no effect
    assign take = hsel && hready && htrans[1] && (hsize == VST_HSIZE_WORD);
    assign rd_addr = haddr[7:0];

    // Zero wait state: the slave is always ready and always answers OKAY
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= VST_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= VST_HRESP_OKAY;
        end
    end

    // Read data is sampled in the address phase so it stands in the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata <= VST_RST_WORD;
        end else if (take && !hwrite) begin
            hrdata <= rd_data;
        end
    end

    // Write address is held until hwdata arrives in the data phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take && hwrite;
            if (take && hwrite) begin
                wr_addr_reg <= haddr[7:0];
            end
        end
    end

    assign wr_en = wr_pend_reg;
    assign wr_addr = wr_addr_reg;
    assign wr_data = hwdata;

    a_ready_always: assert property (@(posedge clk_sys) disable iff (rst)
        hreadyout && (hresp == VST_HRESP_OKAY))
        else $error("slave stalled or gave an error response");

endmodule : vst_ahb_slv
`default_nettype wire

// *** vst_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module vst_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic tacc_req,
    input wire logic [15:0] tacc_id,
    output logic tacc_done,
    output logic tacc_err,
    output logic [31:0] tacc_data,
    input wire logic ev_valid,
    input wire logic [15:0] ev_id,
    output logic ev_ready,
    output logic ev_out_valid,
    output logic [15:0] ev_out_id,
    input wire logic ev_out_ready,
    input wire logic cand_active,
    input wire logic cand_ack,
    output logic cand_withdraw
);
    import vst_pkg::*;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    vst_state_t state_reg;
    logic vm_valid_reg;
    logic want_valid_reg;
    logic op_map_reg;
    logic vm_on_pend_reg;
    logic map_pend_reg;
    logic l2_pend_reg;
    logic idle_reg;
    logic err_reg;
    logic table_valid_reg;
    logic [31:0] l2map_reg;
    logic [31:0] entry_addr_reg;
    logic [19:0] base_reg;
    logic [4:0] idb_reg;
    logic struct_reg;
    logic [1:0] size_reg;
    logic in_range;
    logic [31:0] tab_addr;
    logic ctrl_wr;
    logic map_take;
    logic l2_take;
    logic vm_off;
    logic map_off_now;
    logic invalidate;
    logic ent_ack;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and table address calculator

    vst_ahb_slv u_slv (
        .clk_sys(clk_sys),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .rd_data(rd_data),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr)
    );

    vst_tab_addr u_addr (
        .base(base_reg),
        .max_identifier_width_field(idb_reg),
        .ent_size(size_reg),
        .id(tacc_id),
        .in_range(in_range),
        .addr(tab_addr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    assign ctrl_wr = wr_en && (wr_addr == VST_OFF_CTRL);
    // A map write is only acted on while the VM is valid and the idle bit is set
    assign map_take = wr_en && (wr_addr == VST_OFF_MAP) && vm_valid_reg
        && idle_reg;
    assign l2_take = wr_en && (wr_addr == VST_OFF_L2MAP) && idle_reg
        && table_valid_reg && struct_reg
        && (wr_data[VST_L2_TYPE_BIT] == VST_L2_TYPE_SPI);
    assign vm_off = ctrl_wr && !wr_data[0] && vm_valid_reg;
    assign ent_ack = (state_reg == VST_S_ENT_RD) && mem_ack;
    assign map_off_now = ent_ack && op_map_reg && !want_valid_reg
        && mem_rdata[VST_ENT_VALID];
    assign invalidate = (vm_off || map_off_now) && table_valid_reg;

    // Software-held configuration
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vm_valid_reg <= 1'b0;
            entry_addr_reg <= VST_RST_WORD;
            l2map_reg <= VST_RST_WORD;
        end else begin
            if (ctrl_wr) begin
                vm_valid_reg <= wr_data[0];
            end
            if (wr_en && (wr_addr == VST_OFF_ENTRY)) begin
                entry_addr_reg <= {wr_data[31:2], 2'b00};
            end
            if (l2_take) begin
                l2map_reg <= wr_data;
            end
        end
    end

    // Pending work; the FSM picks each up from its idle state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vm_on_pend_reg <= 1'b0;
            map_pend_reg <= 1'b0;
            l2_pend_reg <= 1'b0;
            want_valid_reg <= 1'b0;
        end else begin
            if (ctrl_wr && wr_data[0] && !vm_valid_reg) begin
                vm_on_pend_reg <= 1'b1;
            end else if (state_reg == VST_S_IDLE) begin
                vm_on_pend_reg <= 1'b0;
            end
            if (map_take) begin
                map_pend_reg <= 1'b1;
                want_valid_reg <= wr_data[0];
            end else if (state_reg == VST_S_IDLE && !vm_on_pend_reg) begin
                map_pend_reg <= 1'b0;
            end
            if (l2_take) begin
                l2_pend_reg <= 1'b1;
            end else if (state_reg == VST_S_IDLE && !vm_on_pend_reg
                && !map_pend_reg) begin
                l2_pend_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle bit: cleared when a map write is taken, set after memory ack

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idle_reg <= VST_RST_IDLE;
        end else if (map_take || l2_take) begin
            idle_reg <= 1'b0;
        end else if (ent_ack && op_map_reg
            && (mem_rdata[VST_ENT_VALID] == want_valid_reg)) begin
            idle_reg <= 1'b1; // No change in validity, nothing to write
        end else if ((state_reg == VST_S_ENT_WR || state_reg == VST_S_L2_WR)
            && mem_ack) begin
            idle_reg <= 1'b1;
        end
    end

    // Error flag: set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else if (invalidate && ev_out_valid) begin
            err_reg <= 1'b1;
        end else if (wr_en && (wr_addr == VST_OFF_STATUS)
            && wr_data[VST_ST_ERR]) begin
            err_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table validity and captured entry fields

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            table_valid_reg <= 1'b0;
            base_reg <= 20'h00000;
            idb_reg <= 5'h00;
            struct_reg <= 1'b0;
            size_reg <= 2'h0;
        end else begin
            if (invalidate) begin
                table_valid_reg <= 1'b0;
            end else if (ent_ack && !op_map_reg && vm_valid_reg
                && mem_rdata[VST_ENT_VALID]) begin
                table_valid_reg <= 1'b1;
            end else if (state_reg == VST_S_ENT_WR && mem_ack
                && want_valid_reg && vm_valid_reg) begin
                table_valid_reg <= 1'b1;
            end
            // Fields are taken from the entry when it is read as valid or a map write sets it valid
            if (ent_ack && (op_map_reg ? want_valid_reg
                : mem_rdata[VST_ENT_VALID])) begin
                base_reg <= mem_rdata[VST_ENT_BASE_LSB +: 20];
                idb_reg <= mem_rdata[VST_ENT_IDB_LSB +: 5];
                size_reg <= mem_rdata[VST_ENT_SIZE_LSB +: 2];
                struct_reg <= mem_rdata[VST_ENT_STRUCT]
                    && VST_TABLE_LEVELS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer for entry updates, sub-table maps and table reads

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= VST_S_IDLE;
            op_map_reg <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= VST_RST_WORD;
            mem_wdata <= VST_RST_WORD;
            tacc_done <= 1'b0;
            tacc_err <= 1'b0;
            tacc_data <= VST_RST_WORD;
        end else begin
            tacc_done <= 1'b0;
            unique case (state_reg)
                VST_S_IDLE: begin
                    if (vm_on_pend_reg || map_pend_reg) begin
                        // Entry is read first so only the flag bit changes
                        op_map_reg <= !vm_on_pend_reg;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= entry_addr_reg;
                        state_reg <= VST_S_ENT_RD;
                    end else if (l2_pend_reg) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= {base_reg, 12'h000}
                            + {14'h0000, l2map_reg[VST_L2_IDX_LSB +: 16],
                            2'b00};
                        mem_wdata <= 32'h0000_0001;
                        state_reg <= VST_S_L2_WR;
                    end else if (tacc_req && !tacc_done) begin
                        if (table_valid_reg && vm_valid_reg && in_range) begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b0;
                            mem_addr <= tab_addr;
                            state_reg <= VST_S_TAB_RD;
                        end else begin
                            tacc_done <= 1'b1;
                            tacc_err <= 1'b1;
                        end
                    end
                end
                VST_S_ENT_RD: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        if (op_map_reg && (mem_rdata[VST_ENT_VALID]
                            != want_valid_reg)) begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b1;
                            mem_wdata <= {mem_rdata[31:1],
                                want_valid_reg};
                            state_reg <= VST_S_ENT_WR;
                        end else begin
                            state_reg <= VST_S_IDLE;
                        end
                    end
                end
                VST_S_ENT_WR, VST_S_L2_WR: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state_reg <= VST_S_IDLE;
                    end
                end
                VST_S_TAB_RD: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        tacc_done <= 1'b1;
                        tacc_err <= 1'b0;
                        tacc_data <= mem_rdata;
                        state_reg <= VST_S_IDLE;
                    end
                end
                default: begin
                    mem_req <= 1'b0;
                    state_reg <= VST_S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-entry event holder and candidate withdrawal

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ev_out_valid <= 1'b0;
            ev_out_id <= 16'h0000;
            ev_ready <= 1'b1;
        end else if (invalidate) begin
            ev_out_valid <= 1'b0;
            ev_ready <= 1'b1;
        end else if (ev_out_valid) begin
            if (ev_out_ready) begin
                ev_out_valid <= 1'b0;
                ev_ready <= 1'b1;
            end
        end else if (ev_valid && ev_ready && table_valid_reg) begin
            ev_out_valid <= 1'b1;
            ev_out_id <= ev_id;
            ev_ready <= 1'b0;
        end
    end

    // An acknowledged candidate needs no withdrawal
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cand_withdraw <= 1'b0;
        end else begin
            cand_withdraw <= invalidate && cand_active
                && !cand_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero

    always_comb begin
        rd_data = VST_RST_WORD;
        unique case (rd_addr)
            VST_OFF_CTRL: rd_data[0] = vm_valid_reg;
            VST_OFF_MAP: rd_data[0] = want_valid_reg;
            VST_OFF_L2MAP: rd_data = l2map_reg;
            VST_OFF_STATUS: begin
                rd_data[VST_ST_IDLE] = idle_reg;
                rd_data[VST_ST_ERR] = err_reg;
                rd_data[VST_ST_TVALID] = table_valid_reg;
            end
            VST_OFF_IDR2: begin
                rd_data[VST_IDR2_IDB_LSB +: 5] = VST_MAX_MAX_IDENTIFIER_WIDTH_FIELD;
                rd_data[VST_IDR2_LEV_BIT] = VST_TABLE_LEVELS;
            end
            VST_OFF_ENTRY: rd_data = entry_addr_reg;
            default: rd_data = VST_RST_WORD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_idle_map_clear: assert property (@(posedge clk_sys) disable iff (rst)
        map_take |=> !idle_reg)
        else $error("idle not cleared after a map write");

    a_idle_after_write: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(idle_reg) && (state_reg != VST_S_IDLE || !op_map_reg
        || $past(state_reg) == VST_S_ENT_WR || $past(state_reg)
        == VST_S_L2_WR) |-> $past(mem_ack))
        else $error("idle set before memory write was acknowledged");

    a_no_invalid_read: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == VST_S_IDLE) ##1 (state_reg == VST_S_TAB_RD)
        |-> $past(table_valid_reg) && mem_req && !mem_we)
        else $error("table read issued while table invalid");

    a_range_check: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == VST_S_IDLE && tacc_req && !tacc_done && !in_range
        && !vm_on_pend_reg && !map_pend_reg && !l2_pend_reg)
        |=> tacc_done && tacc_err && !mem_req)
        else $error("out of range identifier not refused");

    a_enable_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == VST_S_ENT_WR) && want_valid_reg
        |-> mem_we && mem_wdata[VST_ENT_VALID])
        else $error("enabling write does not set the flag");

    a_disable_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == VST_S_ENT_WR) && !want_valid_reg
        |-> mem_we && !mem_wdata[VST_ENT_VALID] && !table_valid_reg)
        else $error("disabling write wrong");

    a_events_dropped: assert property (@(posedge clk_sys) disable iff (rst)
        invalidate && ev_out_valid |=> !ev_out_valid && err_reg)
        else $error("held event not dropped");

    a_withdraw_cand: assert property (@(posedge clk_sys) disable iff (rst)
        invalidate && cand_active && !cand_ack |=> cand_withdraw)
        else $error("candidate not withdrawn");

    a_l2_two_level: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == VST_S_IDLE) ##1 (state_reg == VST_S_L2_WR)
        |-> $past(struct_reg) && $past(table_valid_reg))
        else $error("sub-table map written without a two-level table");

    a_struct_forced: assert property (@(posedge clk_sys) disable iff (rst)
        !VST_TABLE_LEVELS |-> !struct_reg)
        else $error("structure not forced to single level");

endmodule : vst_ctrl
`default_nettype wire

// *** vst_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vst_mem_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] delay,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] mem [0:255];
    logic [1:0] wait_reg;
    ////////////////////////////////////////////////////////////////////////
    // One access at a time; read data flips outside the ack so stale
    // values cannot pass for a real answer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_reg <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (wait_reg == delay) begin
                    wait_reg <= 2'h0;
                    mem_ack <= 1'b1;
                    if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
                    else mem_rdata <= mem[mem_addr[9:2]];
                end else wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule : vst_mem_model
`default_nettype wire

// *** vst_pkg.sv ***
package vst_pkg;

    // Register byte offsets
    localparam logic [7:0] VST_OFF_CTRL = 8'h00;
    localparam logic [7:0] VST_OFF_MAP = 8'h04;
    localparam logic [7:0] VST_OFF_L2MAP = 8'h08;
    localparam logic [7:0] VST_OFF_STATUS = 8'h0C;
    localparam logic [7:0] VST_OFF_IDR2 = 8'h10;
    localparam logic [7:0] VST_OFF_ENTRY = 8'h14;

    // Status register bits
    localparam int VST_ST_IDLE = 0;
    localparam int VST_ST_ERR = 1;
    localparam int VST_ST_TVALID = 2;

    // Second identification register fields
    localparam int VST_IDR2_IDB_LSB = 0;
    localparam int VST_IDR2_LEV_BIT = 8;
    localparam logic [4:0] VST_MAX_MAX_IDENTIFIER_WIDTH_FIELD = 5'h10;
    localparam logic VST_TABLE_LEVELS = 1'b1;

    // Level-two map register fields
    localparam int VST_L2_TYPE_BIT = 0;
    localparam int VST_L2_IDX_LSB = 16;
    localparam logic VST_L2_TYPE_SPI = 1'b1;

    // Level-two VM table entry word layout
    localparam int VST_ENT_VALID = 0;
    localparam int VST_ENT_IDB_LSB = 1;
    localparam int VST_ENT_STRUCT = 6;
    localparam int VST_ENT_SIZE_LSB = 7;
    localparam int VST_ENT_BASE_LSB = 12;

    // Reset values
    localparam logic [31:0] VST_RST_WORD = 32'h0000_0000;
    localparam logic VST_RST_IDLE = 1'b1;

    // AHB encodings
    localparam logic [2:0] VST_HSIZE_WORD = 3'h2;
    localparam logic VST_HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        VST_S_IDLE = 3'b000,
        VST_S_ENT_RD = 3'b001,
        VST_S_ENT_WR = 3'b010,
        VST_S_L2_WR = 3'b011,
        VST_S_TAB_RD = 3'b100
    } vst_state_t;

endpackage : vst_pkg

// *** vst_tab_addr.sv ***
`timescale 1ns/1ps
`default_nettype none
module vst_tab_addr (
    input wire logic [19:0] base,
    input wire logic [4:0] max_identifier_width_field,
    input wire logic [1:0] ent_size,
    input wire logic [15:0] id,
    output logic in_range,
    output logic [31:0] addr
);
    import vst_pkg::*;

    logic [31:0] id_ext;
    logic [31:0] limit;

    // Identifiers run from zero to two to the width, minus one
    assign id_ext = {16'h0000, id};
    assign limit = 32'h0000_0001 << max_identifier_width_field;
    assign in_range = (id_ext < limit);

    // Entries are 4, 8, 16 or 32 bytes; base is 4 KiB aligned
    assign addr = {base, 12'h000} + (id_ext << ({3'h0, ent_size} + 5'h02));

endmodule : vst_tab_addr
`default_nettype wire
